/* File: ssra_register_bank.v */
// Purpose: status bank and mode/supply control register behind the serial port
// Assumes: event, level and control inputs come from core clock logic
// Notes:   clearable flags are cleared by any write frame to their address
`include "ssra_consts.vh"

module ssra_register_bank #(
  parameter [7:0] FAM_PROD_ID = 8'h5a  // arbitrary identification value
) (
  // clock and reset
  input  wire       core_clk_in,
  input  wire       rstn_in,
  // serial pins
  input  wire       spi_csn_in,
  input  wire       spi_sck_in,
  input  wire       spi_si_in,
  output wire       spi_so_out,
  output wire       spi_so_oe_out,
  // device state controls
  input  wire       soft_reset_in,
  input  wire       restart_in,
  input  wire       hw_mode_load_in,
  input  wire [7:0] hw_mode_value_in,
  // clearable status events, one byte per register
  input  wire [7:0] ev_supply_two_in,
  input  wire [7:0] ev_supply_one_in,
  input  wire [7:0] ev_thermal_in,
  input  wire [7:0] ev_device_in,
  input  wire [7:0] ev_bus_one_in,
  input  wire [7:0] ev_bus_two_in,
  input  wire [7:0] ev_wake_one_in,
  input  wire [7:0] ev_wake_two_in,
  input  wire [7:0] ev_hs_oc_ot_in,
  input  wire [7:0] ev_hs_ol_in,
  // live read-only values
  input  wire [7:0] wake_input_levels_in,
  input  wire [7:0] selective_wake_status_in,
  input  wire [7:0] selective_wake_error_count_in,
  input  wire [7:0] clock_recovery_average_in,
  // control outputs
  output reg  [7:0] mode_supply_control_out,
  output reg        write_seen_out
);

  localparam NUM_RC = 10;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // index of a clearable register, 4'hf when the address is not one
  function [3:0] rc_index;
    input [6:0] a;
    begin
      case (a)
        `SSRA_A_SUP_TWO:  rc_index = 4'h0;
        `SSRA_A_SUP_ONE:  rc_index = 4'h1;
        `SSRA_A_THERMAL:  rc_index = 4'h2;
        `SSRA_A_DEVICE:   rc_index = 4'h3;
        `SSRA_A_BUS_ONE:  rc_index = 4'h4;
        `SSRA_A_BUS_TWO:  rc_index = 4'h5;
        `SSRA_A_WAKE_ONE: rc_index = 4'h6;
        `SSRA_A_WAKE_TWO: rc_index = 4'h7;
        `SSRA_A_HS_OC_OT: rc_index = 4'h8;
        `SSRA_A_HS_OL:    rc_index = 4'h9;
        default:          rc_index = 4'hf;
      endcase
    end
  endfunction

  function [7:0] rc_mask;
    input [3:0] i;
    begin
      case (i)
        4'h0:    rc_mask = `SSRA_M_SUP_TWO;
        4'h1:    rc_mask = `SSRA_M_SUP_ONE;
        4'h2:    rc_mask = `SSRA_M_THERMAL;
        4'h3:    rc_mask = `SSRA_M_DEVICE;
        4'h4:    rc_mask = `SSRA_M_BUS_ONE;
        4'h5:    rc_mask = `SSRA_M_BUS_TWO;
        4'h6:    rc_mask = `SSRA_M_WAKE_ONE;
        4'h7:    rc_mask = `SSRA_M_WAKE_TWO;
        4'h8:    rc_mask = `SSRA_M_HS_OC_OT;
        4'h9:    rc_mask = `SSRA_M_HS_OL;
        default: rc_mask = 8'h00;
      endcase
    end
  endfunction

  function [7:0] rc_reset;
    input [3:0] i;
    begin
      if (i == 4'h1)
        rc_reset = `SSRA_RST_SUP_ONE;
      else
        rc_reset = `SSRA_RST_STATUS;
    end
  endfunction

  // ------------------------------------------------------------
  // frame shifter
  // ------------------------------------------------------------
  wire       addr_req;
  wire [6:0] addr;
  wire       frame_done;
  wire       frame_wr;
  wire [7:0] frame_data;
  reg  [7:0] rd_data;

  ssra_frame_shifter u_shifter (
    .core_clk_in    (core_clk_in),
    .rstn_in        (rstn_in),
    .spi_csn_in     (spi_csn_in),
    .spi_sck_in     (spi_sck_in),
    .spi_si_in      (spi_si_in),
    .spi_so_out     (spi_so_out),
    .spi_so_oe_out  (spi_so_oe_out),
    .addr_req_out   (addr_req),
    .addr_out       (addr),
    .rd_data_in     (rd_data),
    .frame_done_out (frame_done),
    .frame_wr_out   (frame_wr),
    .frame_data_out (frame_data)
  );

  // ------------------------------------------------------------
  // event gathering
  // ------------------------------------------------------------
  wire [7:0] events [0:NUM_RC-1];

  assign events[0] = ev_supply_two_in;
  assign events[1] = ev_supply_one_in;
  assign events[2] = ev_thermal_in;
  assign events[3] = ev_device_in;
  assign events[4] = ev_bus_one_in;
  assign events[5] = ev_bus_two_in;
  assign events[6] = ev_wake_one_in;
  assign events[7] = ev_wake_two_in;
  assign events[8] = ev_hs_oc_ot_in;
  assign events[9] = ev_hs_ol_in;

  // write decode; read frames never touch state
  wire       write_frame = frame_done & frame_wr;
  wire [3:0] wr_index    = rc_index(addr);
  wire       wr_ctrl     = write_frame && addr == `SSRA_A_MODE_SUPPLY;

  // ------------------------------------------------------------
  // clearable status registers
  // ------------------------------------------------------------
  reg [7:0] rc_reg [0:NUM_RC-1];
  integer   k;

  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (k = 0; k < NUM_RC; k = k + 1)
        rc_reg[k] <= rc_reset(k[3:0]);
    end
    else if (soft_reset_in)
    begin
      for (k = 0; k < NUM_RC; k = k + 1)
        rc_reg[k] <= rc_reset(k[3:0]);
    end
    else
    begin
      // a new event in the clearing cycle survives the clear
      for (k = 0; k < NUM_RC; k = k + 1)
      begin
        if (write_frame && wr_index == k[3:0])
          rc_reg[k] <= events[k] & rc_mask(k[3:0]);
        else
          rc_reg[k] <= rc_reg[k] | (events[k] & rc_mask(k[3:0]));
      end
    end
  end

  // ------------------------------------------------------------
  // mode and supply control register
  // ------------------------------------------------------------
  // host writes first, hardware update on top of its own bits only
  reg [7:0] next_ctrl;

  always @*
  begin
    next_ctrl = mode_supply_control_out;
    if (wr_ctrl)
      next_ctrl = frame_data;
    if (hw_mode_load_in)
      next_ctrl = (next_ctrl & ~`SSRA_HW_MODE_SUP) |
                  (hw_mode_value_in & `SSRA_HW_MODE_SUP);
    if (restart_in)
      next_ctrl = (mode_supply_control_out & `SSRA_KEEP_MODE_SUP) |
                  (`SSRA_RSTRT_MODE_SUP & ~`SSRA_KEEP_MODE_SUP);
  end

  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      mode_supply_control_out <= `SSRA_RST_MODE_SUPPLY;
    else if (soft_reset_in)
      mode_supply_control_out <= `SSRA_RST_MODE_SUPPLY;
    else
      mode_supply_control_out <= next_ctrl;
  end

  // pulses once per accepted write frame to any address
  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      write_seen_out <= 1'b0;
    else
      write_seen_out <= write_frame;
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // sampled when the address byte completes, before any write of this
  // frame lands, so a write frame returns the old contents
  reg [3:0] rd_index;

  always @*
  begin
    rd_index = rc_index(addr);
    rd_data  = 8'h00;
    if (rd_index != 4'hf)
      rd_data = rc_reg[rd_index] & rc_mask(rd_index);
    else
    begin
      case (addr)
        `SSRA_A_MODE_SUPPLY: rd_data = mode_supply_control_out;
        `SSRA_A_WAKE_LVL:    rd_data = wake_input_levels_in & `SSRA_M_WAKE_LVL;
        `SSRA_A_SELECTIVE_WAKE_STATUS:    rd_data = selective_wake_status_in & `SSRA_M_SELECTIVE_WAKE_STATUS;
        `SSRA_A_SWK_ECNT:    rd_data = selective_wake_error_count_in & `SSRA_M_SWK_ECNT;
        `SSRA_A_CDR_AVG:     rd_data = clock_recovery_average_in & `SSRA_M_CDR_AVG;
        `SSRA_A_FAM_PROD:    rd_data = FAM_PROD_ID;
        default:             rd_data = 8'h00;
      endcase
    end
  end

endmodule // ssra_register_bank

/* File: ssra_consts.vh */
// Purpose: constants for the serial status and register access block
// Assumes: 7-bit register addresses, byte-wide registers
// Notes:   included by ssra_frame_shifter.v and ssra_register_bank.v
`ifndef SSRA_CONSTS_VH
`define SSRA_CONSTS_VH

// ------------------------------------------------------------
// frame layout
// ------------------------------------------------------------
`define SSRA_FRAME_BITS      5'h10
`define SSRA_ADDR_BITS       5'h08
`define SSRA_MODE_BIT        3'h7

// ------------------------------------------------------------
// register addresses
// ------------------------------------------------------------
`define SSRA_A_MODE_SUPPLY   7'h01
`define SSRA_A_SUP_TWO       7'h40
`define SSRA_A_SUP_ONE       7'h41
`define SSRA_A_THERMAL       7'h42
`define SSRA_A_DEVICE        7'h43
`define SSRA_A_BUS_ONE       7'h44
`define SSRA_A_BUS_TWO       7'h45
`define SSRA_A_WAKE_ONE      7'h46
`define SSRA_A_WAKE_TWO      7'h47
`define SSRA_A_WAKE_LVL      7'h48
`define SSRA_A_HS_OC_OT      7'h54
`define SSRA_A_HS_OL         7'h55
`define SSRA_A_SELECTIVE_WAKE_STATUS      7'h70
`define SSRA_A_SWK_ECNT      7'h71
`define SSRA_A_CDR_AVG       7'h72
`define SSRA_A_FAM_PROD      7'h7e

// ------------------------------------------------------------
// implemented-bit masks (zero bits are reserved)
// ------------------------------------------------------------
`define SSRA_M_SUP_TWO       8'h5f
`define SSRA_M_SUP_ONE       8'hff
`define SSRA_M_THERMAL       8'h07
`define SSRA_M_DEVICE        8'hcf
`define SSRA_M_BUS_ONE       8'h7f
`define SSRA_M_BUS_TWO       8'h07
`define SSRA_M_WAKE_ONE      8'h77
`define SSRA_M_WAKE_TWO      8'h30
`define SSRA_M_WAKE_LVL      8'hf7
`define SSRA_M_HS_OC_OT      8'h0f
`define SSRA_M_HS_OL         8'h0f
`define SSRA_M_SELECTIVE_WAKE_STATUS      8'h4f
`define SSRA_M_SWK_ECNT      8'h3f
`define SSRA_M_CDR_AVG       8'hff

// ------------------------------------------------------------
// reset, restart, hardware-load and first-byte values
// ------------------------------------------------------------
`define SSRA_RST_SUP_ONE     8'h80
`define SSRA_RST_STATUS      8'h00
`define SSRA_RST_MODE_SUPPLY 8'h00
`define SSRA_RSTRT_MODE_SUP  8'h00
`define SSRA_KEEP_MODE_SUP   8'h23
`define SSRA_HW_MODE_SUP     8'hfc
`define SSRA_FIRST_BYTE      8'h00

`endif

/* File: ssra_frame_shifter.v */
// Purpose: oversampling serial slave that cuts 16-bit access frames
// Assumes: serial clock idles low, input taken on falling edge, lsb first;
//          each serial clock half period spans at least four core clocks
// Notes:   frames that are not exactly 16 bits long are dropped
`include "ssra_consts.vh"

module ssra_frame_shifter (
  // clock and reset
  input  wire       core_clk_in,
  input  wire       rstn_in,
  // serial pins
  input  wire       spi_csn_in,
  input  wire       spi_sck_in,
  input  wire       spi_si_in,
  output reg        spi_so_out,
  output wire       spi_so_oe_out,
  // register side
  output reg        addr_req_out,
  output reg  [6:0] addr_out,
  input  wire [7:0] rd_data_in,
  output reg        frame_done_out,
  output reg        frame_wr_out,
  output reg  [7:0] frame_data_out
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg  [2:0]  csn_sync;
  reg  [2:0]  sck_sync;
  reg  [1:0]  si_sync;
  reg  [15:0] rx_shift;
  reg  [7:0]  tx_shift;
  reg  [4:0]  bit_cnt;
  reg         overrun;

  wire csn_fall = csn_sync[2] & ~csn_sync[1];
  wire csn_rise = ~csn_sync[2] & csn_sync[1];
  wire sck_fall = sck_sync[2] & ~sck_sync[1];
  wire sck_rise = ~sck_sync[2] & sck_sync[1];
  wire active   = ~csn_sync[1];
  wire [15:0] next_rx = {si_sync[1], rx_shift[15:1]};

  // bit 0 goes out at select, the rest shift out from the second rising edge
  localparam [7:0] FIRST_BYTE = `SSRA_FIRST_BYTE;

  assign spi_so_oe_out = active;

  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      csn_sync <= 3'h7;
      sck_sync <= 3'h0;
      si_sync  <= 2'h0;
    end
    else
    begin
      csn_sync <= {csn_sync[1:0], spi_csn_in};
      sck_sync <= {sck_sync[1:0], spi_sck_in};
      si_sync  <= {si_sync[0], spi_si_in};
    end
  end

  // ------------------------------------------------------------
  // frame shifting
  // ------------------------------------------------------------
  always @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rx_shift       <= 16'h0000;
      tx_shift       <= 8'h00;
      bit_cnt        <= 5'h00;
      overrun        <= 1'b0;
      spi_so_out     <= 1'b0;
      addr_req_out   <= 1'b0;
      addr_out       <= 7'h00;
      frame_done_out <= 1'b0;
      frame_wr_out   <= 1'b0;
      frame_data_out <= 8'h00;
    end
    else
    begin
      addr_req_out   <= 1'b0;
      frame_done_out <= 1'b0;
      if (csn_fall)
      begin
        bit_cnt    <= 5'h00;
        overrun    <= 1'b0;
        tx_shift   <= {1'b0, FIRST_BYTE[7:1]};
        spi_so_out <= FIRST_BYTE[0];
      end
      else if (active && sck_fall)
      begin
        rx_shift <= next_rx;
        if (bit_cnt == `SSRA_FRAME_BITS)
          overrun <= 1'b1;
        else
          bit_cnt <= bit_cnt + 5'h01;
        // address known after the first byte, data byte follows
        if (bit_cnt == `SSRA_ADDR_BITS - 5'h01)
        begin
          addr_req_out <= 1'b1;
          addr_out     <= next_rx[14:8];
        end
      end
      else if (active && sck_rise && bit_cnt != 5'h00)
      begin
        if (bit_cnt == `SSRA_ADDR_BITS)
        begin
          spi_so_out <= rd_data_in[0];
          tx_shift   <= {1'b0, rd_data_in[7:1]};
        end
        else
        begin
          spi_so_out <= tx_shift[0];
          tx_shift   <= {1'b0, tx_shift[7:1]};
        end
      end
      // a frame counts only if exactly 16 bits arrived
      if (csn_rise && bit_cnt == `SSRA_FRAME_BITS && !overrun)
      begin
        frame_done_out <= 1'b1;
        frame_wr_out   <= rx_shift[`SSRA_MODE_BIT];
        frame_data_out <= rx_shift[15:8];
      end
    end
  end

endmodule // ssra_frame_shifter

/* File: ssra_register_bank_props.sv */
// Purpose: port timing checks for the status bank
// Assumes: one core clock domain, async active-low reset
// Notes:   serial bit timing is judged by the bench
`include "ssra_consts.vh"
module ssra_register_bank_props (
  // clock and reset
  input wire logic       core_clk_in,
  input wire logic       rstn_in,
  // serial and device controls
  input wire logic       spi_csn_in,
  input wire logic       spi_so_oe_out,
  input wire logic       soft_reset_in,
  input wire logic       restart_in,
  input wire logic       hw_mode_load_in,
  input wire logic [7:0] hw_mode_value_in,
  // outputs under watch
  input wire logic [7:0] mode_supply_control_out,
  input wire logic       write_seen_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  // the write pulse is registered from the same strobe that updates the bank
  sequence s_ws_now;
    write_seen_out;
  endsequence
  chk_oe_idle_low: assert property (spi_csn_in [*4] |-> !spi_so_oe_out)
    else $error("output enable high while deselected");
  chk_oe_sel_high: assert property (!spi_csn_in [*4] |-> spi_so_oe_out)
    else $error("output enable low while selected");
  chk_ws_one_pulse: assert property (write_seen_out |=> !write_seen_out)
    else $error("write pulse longer than one cycle");
  chk_ws_after_frame: assert property (write_seen_out |-> $past(spi_csn_in, 3))
    else $error("write pulse without a closed frame");
  chk_ctrl_cause: assert property ($changed(mode_supply_control_out) |->
    ($past(restart_in) || $past(hw_mode_load_in) || $past(soft_reset_in)) or s_ws_now)
    else $error("control changed without a cause");
  chk_soft_reset_load: assert property (soft_reset_in |=> mode_supply_control_out == `SSRA_RST_MODE_SUPPLY)
    else $error("soft reset value not loaded");
  chk_restart_keep: assert property (restart_in && !soft_reset_in |=>
    ((mode_supply_control_out ^ $past(mode_supply_control_out)) & `SSRA_KEEP_MODE_SUP) == 8'h00 &&
    (mode_supply_control_out & ~`SSRA_KEEP_MODE_SUP) == (`SSRA_RSTRT_MODE_SUP & ~`SSRA_KEEP_MODE_SUP))
    else $error("restart value wrong");
  chk_hw_load_bits: assert property (hw_mode_load_in && !restart_in && !soft_reset_in |=>
    (mode_supply_control_out & `SSRA_HW_MODE_SUP) == ($past(hw_mode_value_in) & `SSRA_HW_MODE_SUP))
    else $error("hardware load not taken");
  chk_hw_rw_kept: assert property (hw_mode_load_in && !restart_in && !soft_reset_in |=>
    ((mode_supply_control_out ^ $past(mode_supply_control_out)) & ~`SSRA_HW_MODE_SUP) == 8'h00 or s_ws_now)
    else $error("hardware load touched host bits");
endmodule // ssra_register_bank_props

bind ssra_register_bank ssra_register_bank_props i_props (.core_clk_in, .rstn_in, .spi_csn_in, .spi_so_oe_out,
  .soft_reset_in, .restart_in, .hw_mode_load_in, .hw_mode_value_in, .mode_supply_control_out, .write_seen_out);

/* File: ssra_spi_host.sv */
// Purpose: serial master model that issues access frames
// Assumes: sck idles low, data lsb first, bits taken on sck fall
// Notes:   frame length is a call argument so bad lengths can be sent
module ssra_spi_host (
  // clock
  input  wire logic core_clk_in,
  // serial pins
  output logic      csn_out,
  output logic      sck_out,
  output logic      si_out,
  input  wire logic so_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // half period above the 4-cycle minimum so the oversampler keeps up
  localparam int HALF = 6;
  initial
  begin
    csn_out = 1'b1;
    sck_out = 1'b0;
    si_out  = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d, input int nb, output logic [7:0] q);
    logic [16:0] f;
    f = {1'b0, d, w, a};
    q = 8'h00;
    wt(1);
    csn_out = 1'b0;
    wt(HALF);
    for (int i = 0; i < nb; i++)
    begin
      wt(HALF);
      // data moves on the rising edge so it is steady when the bank samples on the fall
      sck_out = 1'b1;
      si_out  = f[i];
      wt(HALF);
      if (i > 7 && i < 16)
        q[i-8] = so_in;
      sck_out = 1'b0;
    end
    wt(HALF);
    csn_out = 1'b1;
    // a released line must not keep showing the last bit
    si_out = ~si_out;
    wt(8);
  endtask
endmodule // ssra_spi_host

/* File: ssra_register_bank_test.sv */
// Purpose: self-checking bench for the status bank
// Assumes: serial master model drives the pins
// Notes:   host always writes zero into reserved positions
`include "ssra_consts.vh"
module ssra_register_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk_in;
  logic       rstn_in;
  wire        spi_csn_in;
  wire        spi_sck_in;
  wire        spi_si_in;
  wire        spi_so_out;
  logic       soft_reset_in;
  logic       restart_in;
  logic       hw_mode_load_in;
  logic [7:0] hw_mode_value_in;
  logic [7:0] ev [10];
  logic [7:0] lv [4];
  wire  [7:0] ctrl;
  int         fails;
  int         n_checks;
  logic [7:0] q;
  logic [6:0] ca [10] = '{`SSRA_A_SUP_TWO, `SSRA_A_SUP_ONE, `SSRA_A_THERMAL, `SSRA_A_DEVICE, `SSRA_A_BUS_ONE,
    `SSRA_A_BUS_TWO, `SSRA_A_WAKE_ONE, `SSRA_A_WAKE_TWO, `SSRA_A_HS_OC_OT, `SSRA_A_HS_OL};
  logic [7:0] cm [10] = '{`SSRA_M_SUP_TWO, `SSRA_M_SUP_ONE, `SSRA_M_THERMAL, `SSRA_M_DEVICE, `SSRA_M_BUS_ONE,
    `SSRA_M_BUS_TWO, `SSRA_M_WAKE_ONE, `SSRA_M_WAKE_TWO, `SSRA_M_HS_OC_OT, `SSRA_M_HS_OL};
  logic [6:0] la [4] = '{`SSRA_A_WAKE_LVL, `SSRA_A_SELECTIVE_WAKE_STATUS, `SSRA_A_SWK_ECNT, `SSRA_A_CDR_AVG};
  logic [7:0] lm [4] = '{`SSRA_M_WAKE_LVL, `SSRA_M_SELECTIVE_WAKE_STATUS, `SSRA_M_SWK_ECNT, `SSRA_M_CDR_AVG};

  ssra_register_bank i_ssra_register_bank (.core_clk_in, .rstn_in, .spi_csn_in, .spi_sck_in, .spi_si_in,
    .spi_so_out, .spi_so_oe_out(), .soft_reset_in, .restart_in, .hw_mode_load_in, .hw_mode_value_in,
    .ev_supply_two_in(ev[0]), .ev_supply_one_in(ev[1]), .ev_thermal_in(ev[2]), .ev_device_in(ev[3]),
    .ev_bus_one_in(ev[4]), .ev_bus_two_in(ev[5]), .ev_wake_one_in(ev[6]), .ev_wake_two_in(ev[7]),
    .ev_hs_oc_ot_in(ev[8]), .ev_hs_ol_in(ev[9]), .wake_input_levels_in(lv[0]), .selective_wake_status_in(lv[1]),
    .selective_wake_error_count_in(lv[2]), .clock_recovery_average_in(lv[3]),
    .mode_supply_control_out(ctrl), .write_seen_out());
  ssra_spi_host i_ssra_spi_host (.core_clk_in, .csn_out(spi_csn_in), .sck_out(spi_sck_in),
    .si_out(spi_si_in), .so_in(spi_so_out));

  initial
  begin
    core_clk_in = 1'b0;
    forever #4 core_clk_in = ~core_clk_in;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    i_ssra_spi_host.xfer(a, 1'b0, 8'h00, 16, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [7:0] e);
    logic [7:0] r;
    i_ssra_spi_host.xfer(a, 1'b1, d, 16, r);
    chk(r, e);
  endtask
  task automatic end_sim;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    rstn_in = 1'b0;
    soft_reset_in = 1'b0;
    restart_in = 1'b0;
    hw_mode_load_in = 1'b0;
    hw_mode_value_in = 8'h00;
    foreach (ev[k]) ev[k] = 8'h00;
    foreach (lv[k]) lv[k] = 8'hff;
    repeat (3) @(negedge core_clk_in);
    rstn_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    chk(ctrl, `SSRA_RST_MODE_SUPPLY);
    rd(`SSRA_A_SUP_ONE, `SSRA_RST_SUP_ONE);
    rd(`SSRA_A_SUP_ONE, `SSRA_RST_SUP_ONE);
    for (int k = 0; k < 10; k++)
    begin
      @(negedge core_clk_in) ev[k] = 8'hff;
      @(negedge core_clk_in) ev[k] = 8'h00;
      rd(ca[k], cm[k]);
      rd(ca[k], cm[k]);
      wr(ca[k], 8'h00, cm[k]);
      rd(ca[k], 8'h00);
    end
    // an event still present in the clearing cycle must keep its flag
    ev[2] = 8'h01;
    wr(`SSRA_A_THERMAL, 8'h00, 8'h01);
    ev[2] = 8'h00;
    rd(`SSRA_A_THERMAL, 8'h01);
    foreach (la[k]) rd(la[k], lm[k]);
    wr(`SSRA_A_FAM_PROD, 8'h00, 8'h5a);
    rd(`SSRA_A_FAM_PROD, 8'h5a);
    rd(7'h20, 8'h00);
    wr(`SSRA_A_MODE_SUPPLY, 8'h5a, 8'h00);
    chk(ctrl, 8'h5a);
    wr(`SSRA_A_MODE_SUPPLY, 8'ha7, 8'h5a);
    rd(`SSRA_A_MODE_SUPPLY, 8'ha7);
    i_ssra_spi_host.xfer(`SSRA_A_MODE_SUPPLY, 1'b1, 8'h00, 15, q);
    chk(ctrl, 8'ha7);
    i_ssra_spi_host.xfer(`SSRA_A_MODE_SUPPLY, 1'b1, 8'h00, 17, q);
    chk(ctrl, 8'ha7);
    @(negedge core_clk_in);
    hw_mode_value_in = 8'h54;
    hw_mode_load_in = 1'b1;
    @(negedge core_clk_in) hw_mode_load_in = 1'b0;
    @(negedge core_clk_in) chk(ctrl, 8'h57);
    wr(`SSRA_A_MODE_SUPPLY, 8'hff, 8'h57);
    @(negedge core_clk_in) restart_in = 1'b1;
    @(negedge core_clk_in) restart_in = 1'b0;
    @(negedge core_clk_in) chk(ctrl, 8'h23);
    @(negedge core_clk_in) soft_reset_in = 1'b1;
    @(negedge core_clk_in) soft_reset_in = 1'b0;
    @(negedge core_clk_in) chk(ctrl, `SSRA_RST_MODE_SUPPLY);
    rd(`SSRA_A_SUP_ONE, `SSRA_RST_SUP_ONE);
    end_sim();
  end

  // run needs about 60 frames of 200 cycles; the limit leaves wide margin
  initial
  begin
    #400us;
    fails++;
    end_sim();
  end
endmodule // ssra_register_bank_test
